/* File: src/two_wire_target_map.svh */
// Constants of the two-wire register target: addresses, bit counts, timing
`ifndef TWO_WIRE_TARGET_MAP_SVH
`define TWO_WIRE_TARGET_MAP_SVH

// ****************************************************************
// Bus addresses and register range
// ****************************************************************
`define TWT_BUS_ADDR_SEL_LOW   7'h33
`define TWT_BUS_ADDR_SEL_HIGH  7'h36
`define TWT_REG_FIRST          8'h00
`define TWT_REG_LAST           8'h6c
`define TWT_REG_COUNT          109
`define TWT_REG_RESET_VALUE    8'h00
`define TWT_READ_PAST_END      8'h00

// ****************************************************************
// Byte framing on the link
// ****************************************************************
`define TWT_LAST_DATA_BIT      4'h7
`define TWT_ACK_BIT            4'h8
`define TWT_RW_READ            1'b1

// ****************************************************************
// Timing
// ****************************************************************
`define TWT_CLK_PERIOD_NS      5
`define TWT_SCL_MIN_PERIOD_NS  2500
`define TWT_SCL_MIN_CYCLES     ((`TWT_SCL_MIN_PERIOD_NS + `TWT_CLK_PERIOD_NS - 1) / `TWT_CLK_PERIOD_NS)

`endif

/* File: src/two_wire_target_pkg.sv */
// Types shared by the two-wire register target
package two_wire_target_pkg;

  // Byte-level phase of the link, advanced on SCL
  typedef enum logic [2:0] {
    LINK_ADDR,
    LINK_REG,
    LINK_WDATA,
    LINK_RDATA,
    LINK_IGNORE
  } link_state_t;

  // Bus condition tracker in the system clock domain
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_START,
    BUS_XFER
  } bus_state_t;

endpackage : two_wire_target_pkg

/* File: src/sync_two_flop.sv */
// Two flip-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none

module sync_two_flop #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;

  // ****************************************************************
  // Synchroniser chain
  // ****************************************************************
  // First stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule : sync_two_flop

`default_nettype wire

/* File: src/two_wire_register_target.sv */
// Two-wire serial control target with auto-incrementing register file
//
// Summary of operation
// - Answer 0x33 when select low, 0x36 high
// - Bit rate at most 400 kbit/s
// - SDA stays stable while SCL high
// - SDA change with SCL high is control
// - SDA fall with SCL high starts access
// - SDA rise with SCL high ends access
// - Both lines high means idle, no transfer
// - Repeated starts and stops handled cleanly
// - Eight data bits then acknowledge bit
// - Transmitter releases SDA, receiver pulls low
// - Third byte goes to selected register
// - Later bytes auto-increment the register index
// - Index wraps from 0x6c to 0x00
// - Index moves only after whole byte
// - Reads increment; byte after last reads zero
// - Repeated start allows write-then-read combined
`timescale 1ns/100ps
`default_nettype none
`include "two_wire_target_map.svh"

module two_wire_register_target (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe_n,
  input  wire logic       i_addr_sel,
  output logic            o_reg_wr,
  output logic [7:0]      o_reg_addr,
  output logic [7:0]      o_reg_data,
  output logic            o_busy,
  output logic            o_overspeed
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  two_wire_target_pkg::link_state_t link_state;
  two_wire_target_pkg::link_state_t next_link_state;
  two_wire_target_pkg::bus_state_t  bus_state;

  logic [1:0]  pins_sync;
  logic        scl_s;
  logic        sda_s;
  logic        scl_q;
  logic        sda_q;
  logic        start_seen;
  logic        stop_seen;
  logic        scl_rise;
  logic        link_hold;
  logic        link_rst_n;
  logic [8:0]  period_cnt;
  logic        wr_tog_s;
  logic        wr_tog_q;

  logic        addr_sel_s;
  logic [3:0]  bit_cnt;
  logic [7:0]  shreg;
  logic [7:0]  next_byte;
  logic        byte_done;
  logic        addr_match;
  logic        ack_pend;
  logic [7:0]  ptr;
  logic        past_end;
  logic        inc_wrap;
  logic [7:0]  next_ptr_inc;
  logic [7:0]  rd_now;
  logic [7:0]  rd_next;
  logic [7:0]  rd_byte;
  logic [7:0]  mem [0:`TWT_REG_COUNT-1];
  logic        wr_toggle;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;

  // ****************************************************************
  // System clock side: bus condition detection
  // ****************************************************************
  sync_two_flop #(
    .WIDTH (2)
  ) u_pin_sync (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_async  ({~i_scl, ~i_sda}),
    .o_sync   (pins_sync)
  );

  // Lines pass inverted so the cleared chain reads as an idle high bus, no false edge
  assign scl_s = ~pins_sync[1];
  assign sda_s = ~pins_sync[0];

  // Previous line levels for edge detection
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // SDA edges while SCL high are conditions, never data
  assign start_seen = scl_s && scl_q && sda_q && !sda_s;
  assign stop_seen  = scl_s && scl_q && !sda_q && sda_s;
  assign scl_rise   = scl_s && !scl_q;

  // Bus tracker; the link framing and SDA drive logic is held in reset outside a frame, the register index is not
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bus_state <= two_wire_target_pkg::BUS_IDLE;
    end else begin
      case (bus_state)
        two_wire_target_pkg::BUS_IDLE: begin
          if (start_seen) begin
            bus_state <= two_wire_target_pkg::BUS_START;
          end
        end
        two_wire_target_pkg::BUS_START: begin
          if (stop_seen) begin
            bus_state <= two_wire_target_pkg::BUS_IDLE;
          end else if (!scl_s) begin
            bus_state <= two_wire_target_pkg::BUS_XFER;
          end
        end
        default: begin
          if (start_seen) begin
            bus_state <= two_wire_target_pkg::BUS_START;
          end else if (stop_seen) begin
            bus_state <= two_wire_target_pkg::BUS_IDLE;
          end
        end
      endcase
    end
  end

  // Hold and busy flags are registered from the same inputs and change on the same edge as the tracker
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      link_hold <= 1'b1;
      o_busy    <= 1'b0;
    end else begin
      link_hold <= start_seen || stop_seen ||
                   (bus_state == two_wire_target_pkg::BUS_IDLE) ||
                   (bus_state == two_wire_target_pkg::BUS_START && scl_s);
      o_busy    <= start_seen || (bus_state != two_wire_target_pkg::BUS_IDLE && !stop_seen);
    end
  end

  // Link framing and SDA drive logic is reset by a condition and released once SCL is low; index and register file are not
  assign link_rst_n = i_arst_n && !link_hold;

  // Measures SCL rise spacing against the fastest allowed rate
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      period_cnt  <= 9'h000;
      o_overspeed <= 1'b0;
    end else begin
      if (scl_rise) begin
        period_cnt <= 9'h001;
      end else if (period_cnt < 9'(`TWT_SCL_MIN_CYCLES)) begin
        period_cnt <= period_cnt + 9'h001;
      end
      if (scl_rise && o_busy && period_cnt < 9'(`TWT_SCL_MIN_CYCLES)) begin
        o_overspeed <= 1'b1;
      end else if (start_seen) begin
        o_overspeed <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // System clock side: write notifications from the link
  // ****************************************************************
  sync_two_flop #(
    .WIDTH (1)
  ) u_wr_sync (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_async  (wr_toggle),
    .o_sync   (wr_tog_s)
  );

  // Toggle edge marks a stored byte; address and data are stable by then
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_tog_q   <= 1'b0;
      o_reg_wr   <= 1'b0;
      o_reg_addr <= `TWT_REG_FIRST;
      o_reg_data <= `TWT_REG_RESET_VALUE;
    end else begin
      wr_tog_q <= wr_tog_s;
      o_reg_wr <= wr_tog_s ^ wr_tog_q;
      if (wr_tog_s ^ wr_tog_q) begin
        o_reg_addr <= wr_addr;
        o_reg_data <= wr_data;
      end
    end
  end

  // ****************************************************************
  // Link side: bit framing on SCL rising edges
  // ****************************************************************
  sync_two_flop #(
    .WIDTH (1)
  ) u_sel_sync (
    .i_clk    (i_scl),
    .i_arst_n (i_arst_n),
    .i_async  (i_addr_sel),
    .o_sync   (addr_sel_s)
  );

  assign next_byte  = {shreg[6:0], i_sda};
  assign byte_done  = (bit_cnt == `TWT_ACK_BIT);
  assign addr_match = (next_byte[7:1] ==
                       (addr_sel_s ? `TWT_BUS_ADDR_SEL_HIGH : `TWT_BUS_ADDR_SEL_LOW));

  // Counts eight data bits and the acknowledge bit
  always_ff @(posedge i_scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt <= 4'h0;
    end else if (byte_done) begin
      bit_cnt <= 4'h0;
    end else begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // Data is taken while SCL is high, MSB first
  always_ff @(posedge i_scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      shreg <= 8'h00;
    end else if (!byte_done) begin
      shreg <= next_byte;
    end
  end

  // Decides the acknowledge once the eighth bit is in
  always_ff @(posedge i_scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      ack_pend <= 1'b0;
    end else if (bit_cnt == `TWT_LAST_DATA_BIT) begin
      case (link_state)
        two_wire_target_pkg::LINK_ADDR:  ack_pend <= addr_match;
        two_wire_target_pkg::LINK_REG:   ack_pend <= 1'b1;
        two_wire_target_pkg::LINK_WDATA: ack_pend <= 1'b1;
        default:                         ack_pend <= 1'b0;
      endcase
    end else begin
      ack_pend <= 1'b0;
    end
  end

  // Next byte phase, taken at the acknowledge bit
  always_comb begin
    next_link_state = link_state;
    case (link_state)
      two_wire_target_pkg::LINK_ADDR: begin
        if (!ack_pend) begin
          next_link_state = two_wire_target_pkg::LINK_IGNORE;
        end else if (shreg[0] == `TWT_RW_READ) begin
          next_link_state = two_wire_target_pkg::LINK_RDATA;
        end else begin
          next_link_state = two_wire_target_pkg::LINK_REG;
        end
      end
      two_wire_target_pkg::LINK_REG:   next_link_state = two_wire_target_pkg::LINK_WDATA;
      two_wire_target_pkg::LINK_WDATA: next_link_state = two_wire_target_pkg::LINK_WDATA;
      two_wire_target_pkg::LINK_RDATA: begin
        if (i_sda) begin
          next_link_state = two_wire_target_pkg::LINK_IGNORE;  // Host declined more data
        end
      end
      default: next_link_state = two_wire_target_pkg::LINK_IGNORE;
    endcase
  end

  // Byte phase register; restarts at the address byte on every start
  always_ff @(posedge i_scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      link_state <= two_wire_target_pkg::LINK_ADDR;
    end else if (byte_done) begin
      link_state <= next_link_state;
    end
  end

  // ****************************************************************
  // Link side: register index and register file
  // ****************************************************************
  assign inc_wrap     = (ptr >= `TWT_REG_LAST);
  assign next_ptr_inc = inc_wrap ? `TWT_REG_FIRST : ptr + 8'h01;
  assign rd_now       = (past_end || ptr > `TWT_REG_LAST) ? `TWT_READ_PAST_END : mem[ptr[6:0]];
  assign rd_next      = inc_wrap ? `TWT_READ_PAST_END : mem[next_ptr_inc[6:0]];

  // Index moves only at the acknowledge bit, after the whole byte
  always_ff @(posedge i_scl or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ptr      <= `TWT_REG_FIRST;
      past_end <= 1'b0;
    end else if (byte_done) begin
      case (link_state)
        two_wire_target_pkg::LINK_REG: begin
          ptr      <= shreg;
          past_end <= 1'b0;
        end
        two_wire_target_pkg::LINK_WDATA: begin
          ptr      <= next_ptr_inc;
          past_end <= 1'b0;
        end
        two_wire_target_pkg::LINK_RDATA: begin
          ptr      <= next_ptr_inc;
          past_end <= inc_wrap;
        end
        default: begin
          ptr      <= ptr;
          past_end <= past_end;
        end
      endcase
    end
  end

  // Stores data bytes; bytes aimed past the last register are dropped
  always_ff @(posedge i_scl or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < `TWT_REG_COUNT; i++) begin
        mem[i] <= `TWT_REG_RESET_VALUE;
      end
    end else if (byte_done && link_state == two_wire_target_pkg::LINK_WDATA &&
                 ptr <= `TWT_REG_LAST) begin
      mem[ptr[6:0]] <= shreg;
    end
  end

  // Write notice toward the system clock side
  always_ff @(posedge i_scl or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_toggle <= 1'b0;
      wr_addr   <= `TWT_REG_FIRST;
      wr_data   <= `TWT_REG_RESET_VALUE;
    end else if (byte_done && link_state == two_wire_target_pkg::LINK_WDATA &&
                 ptr <= `TWT_REG_LAST) begin
      wr_toggle <= !wr_toggle;
      wr_addr   <= ptr;
      wr_data   <= shreg;
    end
  end

  // Byte to send next: current index after addressing, incremented after each read
  always_ff @(posedge i_scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rd_byte <= `TWT_READ_PAST_END;
    end else if (byte_done) begin
      if (link_state == two_wire_target_pkg::LINK_ADDR) begin
        rd_byte <= rd_now;
      end else if (link_state == two_wire_target_pkg::LINK_RDATA) begin
        rd_byte <= rd_next;
      end
    end
  end

  // ****************************************************************
  // Link side: SDA drive on SCL falling edges
  // ****************************************************************
  // Open-drain: pull low for acknowledge or a zero read bit, else release
  always_ff @(negedge i_scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      o_sda_oe_n <= 1'b1;
    end else if (bit_cnt == `TWT_ACK_BIT) begin
      o_sda_oe_n <= !ack_pend;
    end else if (link_state == two_wire_target_pkg::LINK_RDATA) begin
      o_sda_oe_n <= rd_byte[~bit_cnt[2:0]];
    end else begin
      o_sda_oe_n <= 1'b1;
    end
  end

  // Driven level is always low; only the enable moves
  always_ff @(negedge i_scl or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sda <= 1'b0;
    end else begin
      o_sda <= 1'b0;
    end
  end

endmodule : two_wire_register_target

`default_nettype wire

/* File: bench/two_wire_target_checker.sv */
// Concurrent checks on the ports of the two-wire register target
`timescale 1ns/100ps
`default_nettype none

module two_wire_target_checker (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic       o_sda,
  input  wire logic       o_sda_oe_n,
  input  wire logic       o_reg_wr,
  input  wire logic [7:0] o_reg_addr,
  input  wire logic [7:0] o_reg_data,
  input  wire logic       o_busy,
  input  wire logic       o_overspeed
);
  logic       scl_q;
  logic [9:0] gap;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  // Cycles since the last SCL rise, saturating
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_q <= 1'b1;
      gap   <= 10'h3ff;
    end else begin
      scl_q <= i_scl;
      if (i_scl && !scl_q)
        gap <= 10'h000;
      else if (gap != 10'h3ff)
        gap <= gap + 10'h001;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_idle_quiet: assert property (
    !o_busy |-> o_sda_oe_n && !o_reg_wr) else $error("Activity while idle");
  a_open_drain_low: assert property (
    o_sda == 1'b0) else $error("SDA driven high");
  a_wr_one_pulse: assert property (
    o_reg_wr |=> !o_reg_wr) else $error("Store pulse too long");
  a_addr_in_range: assert property (
    o_reg_wr |-> o_reg_addr <= 8'h6c) else $error("Store past last register");
  a_store_holds: assert property (
    !o_reg_wr |-> $stable(o_reg_addr) && $stable(o_reg_data))
    else $error("Store outputs moved between pulses");
  a_wr_after_rise: assert property (
    $rose(o_reg_wr) |-> gap < 10'd12) else $error("Store not after a bit");
  a_start_busy: assert property (
    $fell(i_sda) && i_scl && $past(i_scl) |-> ##[1:8] o_busy)
    else $error("Start not seen");
  a_stop_idle: assert property (
    $rose(i_sda) && i_scl && $past(i_scl) |-> ##[1:8] !o_busy)
    else $error("Stop not seen");
  a_sda_steady_high: assert property (
    i_scl && $past(i_scl) && o_busy |-> $stable(o_sda_oe_n))
    else $error("SDA drive moved while SCL high");
  a_fast_flagged: assert property (
    i_scl && !scl_q && gap < 10'd400 && o_busy |-> ##[1:8] o_overspeed)
    else $error("Fast clock not flagged");

  c_wrap_store: cover property (o_reg_wr && o_reg_addr == 8'h00);
  c_fast_clock: cover property ($rose(o_overspeed));
  c_restart: cover property (o_busy && $fell(i_sda) && i_scl && $past(i_scl));
endmodule : two_wire_target_checker

bind two_wire_register_target two_wire_target_checker chk (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda),
  .o_sda_oe_n(o_sda_oe_n), .o_reg_wr(o_reg_wr), .o_reg_addr(o_reg_addr),
  .o_reg_data(o_reg_data), .o_busy(o_busy), .o_overspeed(o_overspeed));
`default_nettype wire

/* File: bench/two_wire_host_model.sv */
// Behavioural two-wire bus controller driving SCL and SDA
`timescale 1ns/100ps
`default_nettype none

module two_wire_host_model (
  output logic      o_scl,
  output logic      o_sda,
  input  wire logic i_sda
);
  int half = 1300;  // Half SCL period in ns, below 400 kHz

  // SCL rests high outside frames, SDA released
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // One bit: SDA moves mid low phase, sampled just before the fall
  task automatic bit_cycle(input logic b, output logic s);
    #(half / 2) o_sda = b;
    #(half / 2) o_scl = 1'b1;
    #(half) s = i_sda;
    o_scl = 1'b0;
  endtask : bit_cycle

  // Start or repeated start: SDA falls while SCL high
  task automatic start();
    #(half / 2) o_sda = 1'b1;
    #(half / 2) o_scl = 1'b1;
    #(half) o_sda = 1'b0;
    #(half) o_scl = 1'b0;
  endtask : start

  // Stop: SDA rises while SCL high, bus left idle
  task automatic stop();
    o_scl = 1'b0;
    #(half / 2) o_sda = 1'b0;
    #(half / 2) o_scl = 1'b1;
    #(half) o_sda = 1'b1;
    #(half);
  endtask : stop

  // Send a byte MSB first, release SDA for the acknowledge bit
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cycle(b[i], s);
    bit_cycle(1'b1, s);
    ack = ~s;
  endtask : put_byte

  // Receive a byte, acknowledge unless it is the last one
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, s);
      b[i] = s;
    end
    bit_cycle(last, s);
  endtask : get_byte
endmodule : two_wire_host_model
`default_nettype wire

/* File: bench/two_wire_register_target_tb.sv */
// Self-checking testbench of the two-wire register target
`timescale 1ns/100ps
`default_nettype none

module two_wire_register_target_tb;
  logic        clk;
  logic        arst_n = 1'b1;
  logic        addr_sel = 1'b0;
  logic        scl;
  logic        host_sda;
  logic        sda_dut;
  logic        oe_n;
  logic        reg_wr;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_data;
  logic        busy;
  logic        overspeed;
  logic [15:0] wq[$];
  int          mismatches = 0;
  int          checked = 0;
  int          cycles = 0;
  wire         sda = host_sda & (oe_n | sda_dut);  // Pull-up wired AND

  two_wire_register_target dut (.i_clk(clk), .i_arst_n(arst_n), .i_scl(scl),
    .i_sda(sda), .o_sda(sda_dut), .o_sda_oe_n(oe_n), .i_addr_sel(addr_sel),
    .o_reg_wr(reg_wr), .o_reg_addr(reg_addr), .o_reg_data(reg_data),
    .o_busy(busy), .o_overspeed(overspeed));
  two_wire_host_model host (.o_scl(scl), .o_sda(host_sda), .i_sda(sda));

  // 200 MHz system clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Collect stored bytes; cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (reg_wr === 1'b1)
      wq.push_back({reg_addr, reg_data});
    if (cycles == 95000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check8

  task automatic check1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check1

  task automatic expect_wr(input logic [7:0] a, input logic [7:0] d);
    logic [15:0] w;
    w = 16'hxxxx;
    if (wq.size() != 0)
      w = wq.pop_front();
    check8(w[15:8], a);
    check8(w[7:0], d);
  endtask : expect_wr

  // Write three bytes from 6Bh so the index wraps to 00h
  task automatic test_write_wrap();
    logic ack;
    host.start();
    check1(busy, 1'b1);
    host.put_byte(8'h66, ack);
    check1(ack, 1'b1);
    host.put_byte(8'h6b, ack);
    check1(ack, 1'b1);
    host.put_byte(8'h11, ack);
    host.put_byte(8'h22, ack);
    host.put_byte(8'h33, ack);
    host.stop();
    check1(busy, 1'b0);
    expect_wr(8'h6b, 8'h11);
    expect_wr(8'h6c, 8'h22);
    expect_wr(8'h00, 8'h33);
    $display("test_write_wrap done");
  endtask : test_write_wrap

  // Other address is ignored; two stops in a row
  task automatic test_wrong_addr();
    logic ack;
    host.start();
    host.put_byte(8'h6c, ack);
    check1(ack, 1'b0);
    host.put_byte(8'h10, ack);
    host.put_byte(8'h99, ack);
    check1(ack, 1'b0);
    host.stop();
    host.stop();
    check1(busy, 1'b0);
    check1(wq.size() == 0, 1'b1);
    $display("test_wrong_addr done");
  endtask : test_wrong_addr

  // Set index 6Ch, two starts back to back, read past the end
  task automatic test_combined();
    logic       ack;
    logic [7:0] rd;
    @(posedge clk);
    #1 addr_sel = 1'b1;
    host.start();
    host.put_byte(8'h6c, ack);
    check1(ack, 1'b1);
    host.put_byte(8'h6c, ack);
    host.start();
    host.start();
    host.put_byte(8'h6d, ack);
    check1(ack, 1'b1);
    host.get_byte(1'b0, rd);
    check8(rd, 8'h22);
    host.get_byte(1'b1, rd);
    check8(rd, 8'h00);
    host.stop();
    check1(wq.size() == 0, 1'b1);
    @(posedge clk);
    #1 addr_sel = 1'b0;
    $display("test_combined done");
  endtask : test_combined

  // One byte clocked too fast raises the diagnostic flag
  task automatic test_overspeed();
    logic ack;
    host.half = 500;
    host.start();
    host.put_byte(8'h66, ack);
    host.stop();
    host.half = 1300;
    check1(overspeed, 1'b1);
    $display("test_overspeed done");
  endtask : test_overspeed

  // Reset in mid transfer returns the target to idle
  task automatic test_reset();
    logic ack;
    host.start();
    check1(overspeed, 1'b0);
    host.put_byte(8'h66, ack);
    host.put_byte(8'h05, ack);
    host.put_byte(8'h5a, ack);
    expect_wr(8'h05, 8'h5a);
    @(posedge clk);
    #1 arst_n = 1'b0;
    repeat (5) @(posedge clk);
    check1(busy, 1'b0);
    check1(oe_n, 1'b1);
    check8(reg_addr, 8'h00);
    #1 arst_n = 1'b1;
    repeat (5) @(posedge clk);
    host.stop();
    check1(busy, 1'b0);
    $display("test_reset done");
  endtask : test_reset

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // Main sequence
  initial begin
    #1 arst_n = 1'b0;
    repeat (5) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (10) @(posedge clk);
    test_write_wrap();
    test_wrong_addr();
    test_combined();
    test_overspeed();
    test_reset();
    print_verdict();
  end
endmodule : two_wire_register_target_tb
`default_nettype wire
